// ### src/hssp_defines.svh
// Timing and framing constants for the host serial port
`ifndef HSSP_DEFINES_SVH
`define HSSP_DEFINES_SVH
// ==========================================================
// Word framing
`define HSSP_WORD_W        32
`define HSSP_CNT_W         6
`define HSSP_MODE_ZERO     2'h0
// ==========================================================
// Host clock divider: count N gives a half period of N+1 system clocks
// Seven clocks cover the device's four-clock answer plus the host's two-stage sync
`define HSSP_SCK_HALF      8'h06
`define HSSP_LEAD_HALF     8'h06
`endif

// ### src/hssp_device.sv
// Device end of the host serial port
// Functional notes
// - Mode 0 only: sample rising, shift falling.
// - Both ends agree on mode number.
// - Host sets first bit half period early.
// - Only own chip select frames transfers.
// - Release MISO on deselect, or at a word end with no next word.
// - Other slaves tri-state MISO between transfers.
// - Host actively drives chip select.
// - Dedicated interrupt output toward host.
// - Clock idles low, MSB first.
// - Select active low, per word or message.
// - Word size auto-detected; byte order on 32-bit words only.
// - Interrupt active high, edge or level.
`timescale 1ns/1ns
`include "hssp_defines.svh"
module hssp_device
(
    input  wire logic                       i_clk_sys,
    input  wire logic                       i_arst_n,
    hssp_if.device                          link,
    input  wire logic [`HSSP_WORD_W-1:0]    i_tx_word,
    input  wire logic                       i_tx_valid,
    output logic                            o_tx_taken,
    input  wire logic                       i_irq_req,
    output logic [`HSSP_WORD_W-1:0]         o_rx_word,
    output logic                            o_rx_valid,
    output hssp_pkg::hssp_size_t            o_rx_size,
    output logic                            o_rx_swapped
);
    // ==========================================================
    // Pin synchronisers
    logic [1:0] sck_s_q;
    logic [1:0] mosi_s_q;
    logic [1:0] cs_s_q;
    logic       sck_d1_q;
    logic       cs_d1_q;
    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            sck_s_q  <= 2'h0;
            mosi_s_q <= 2'h0;
            cs_s_q   <= 2'h3;
        end
        else
        begin
            sck_s_q  <= {sck_s_q[0], link.sck};
            mosi_s_q <= {mosi_s_q[0], link.mosi};
            cs_s_q   <= {cs_s_q[0], link.chip_select_n};
        end
    end
    // ==========================================================
    // Edge history, reset to idle pin levels so no false edge follows reset
    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            sck_d1_q <= 1'h0;
            cs_d1_q  <= 1'h1;
        end
        else
        begin
            sck_d1_q <= sck_s_q[1];
            cs_d1_q  <= cs_s_q[1];
        end
    end
    // ==========================================================
    // Edge decode
    wire selected   = !cs_s_q[1];
    wire sck_rise   = selected && sck_s_q[1] && !sck_d1_q;
    wire sck_fall   = selected && !sck_s_q[1] && sck_d1_q;
    wire sel_start  = !cs_s_q[1] && cs_d1_q;
    wire sel_end    = cs_s_q[1] && !cs_d1_q;
    // ==========================================================
    // Shift state
    logic [`HSSP_CNT_W-1:0]  bits_q;
    logic [`HSSP_WORD_W-1:0] rx_sh_q;
    logic [`HSSP_WORD_W-1:0] tx_sh_q;
    logic                    tx_act_q;
    logic                    miso_q;
    logic                    oe_q;
    logic [`HSSP_WORD_W-1:0] rx_word_q;
    logic                    rx_valid_q;
    hssp_pkg::hssp_size_t    size_q;
    logic                    swap_q;
    logic                    irq_q;
    // Words are closed at 32 bits, or at deselect with 8 or 16 bits
    wire word_full  = sck_rise && (bits_q == 6'h1F);
    wire short_end  = sel_end && ((bits_q == 6'h08) || (bits_q == 6'h10));
    wire word_close = word_full || short_end;
    // Next word loads on the last rise, so a held select streams words
    wire load_tx    = (sel_start || word_full) && i_tx_valid;
    wire [`HSSP_WORD_W-1:0] rx_next = {rx_sh_q[`HSSP_WORD_W-2:0], mosi_s_q[1]};
    // Little-endian host puts the sync byte pattern reversed; detect by lane 0 marker
    wire [`HSSP_WORD_W-1:0] rx_full  = word_full ? rx_next : rx_sh_q;
    wire                    le_hint  = word_full && (rx_full[7:0] != 8'h00) && (rx_full[31:24] == 8'h00);
    wire [`HSSP_WORD_W-1:0] rx_swap;
    genvar lane;
    generate
        for (lane = 0; lane < 4; lane++)
        begin : g_lane
            assign rx_swap[8*lane +: 8] = rx_full[8*(3-lane) +: 8];
        end
    endgenerate
    wire [`HSSP_WORD_W-1:0] rx_order = le_hint ? rx_swap : rx_full;
    assign o_tx_taken = load_tx;
    // ==========================================================
    // Bit counter, restarted by every select and every full word
    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
            bits_q <= 6'h00;
        else if (!selected || sel_start || word_full)
            bits_q <= 6'h00;
        else if (sck_rise)
            bits_q <= bits_q + 6'h01;
    end
    // ==========================================================
    // Receive shifter
    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
            rx_sh_q <= 32'h00000000;
        else if (sck_rise)
            rx_sh_q <= rx_next;
    end
    // ==========================================================
    // Transmit shifter; no shift on the fall after the last bit,
    // so a word loaded at the last rise keeps its first bit
    wire tx_shift = sck_fall && (bits_q != 6'h00);
    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
            tx_sh_q <= 32'h00000000;
        else if (load_tx)
            tx_sh_q <= i_tx_word;
        else if (tx_shift)
            tx_sh_q <= {tx_sh_q[`HSSP_WORD_W-2:0], 1'h0};
    end
    // ==========================================================
    // Word in flight; dropped by deselect or a word end with nothing new
    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
            tx_act_q <= 1'h0;
        else if (!selected || word_full)
            tx_act_q <= load_tx;
        else if (load_tx)
            tx_act_q <= 1'h1;
    end
    // ==========================================================
    // MISO drive: only while a loaded word is in flight
    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            miso_q <= 1'h0;
            oe_q   <= 1'h0;
        end
        else
        begin
            miso_q <= tx_sh_q[`HSSP_WORD_W-1];
            oe_q   <= selected && tx_act_q;
        end
    end
    assign link.miso_o  = miso_q;
    assign link.miso_oe = oe_q;
    // ==========================================================
    // Received word, size and byte order
    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            rx_word_q  <= 32'h00000000;
            size_q     <= hssp_pkg::HSSP_SZ_32;
            swap_q     <= 1'h0;
        end
        else
        begin
            if (word_close)
            begin
                rx_word_q <= rx_order;
                swap_q    <= le_hint;
                if (word_full)
                    size_q <= hssp_pkg::HSSP_SZ_32;
                else if (bits_q == 6'h10)
                    size_q <= hssp_pkg::HSSP_SZ_16;
                else
                    size_q <= hssp_pkg::HSSP_SZ_8;
            end
        end
    end
    // ==========================================================
    // Received word strobe, one cycle per closed word
    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
            rx_valid_q <= 1'h0;
        else
            rx_valid_q <= word_close;
    end
    // ==========================================================
    // Interrupt level held while the request stands; host may use edge or level
    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
            irq_q <= 1'h0;
        else
            irq_q <= i_irq_req;
    end
    assign link.irq     = irq_q;
    assign o_rx_word    = rx_word_q;
    assign o_rx_valid   = rx_valid_q;
    assign o_rx_size    = size_q;
    assign o_rx_swapped = swap_q;
endmodule

// ### src/hssp_host.sv
// Host master end of the host serial port
`timescale 1ns/1ns
`include "hssp_defines.svh"
module hssp_host
(
    input  wire logic                       i_clk_sys,
    input  wire logic                       i_arst_n,
    hssp_if.host                            link,
    input  wire logic [`HSSP_WORD_W-1:0]    i_tx_word,
    input  wire logic                       i_start,
    input  wire logic                       i_hold_cs,
    output logic                            o_ready,
    output logic [`HSSP_WORD_W-1:0]         o_rx_word,
    output logic                            o_rx_valid,
    output logic                            o_irq
);
    // ==========================================================
    // Sequencer, mode 0 fixed
    hssp_pkg::hssp_state_t   st_q;
    logic [7:0]              div_q;
    logic [`HSSP_CNT_W-1:0]  bits_q;
    logic                    sck_q;
    logic                    cs_n_q;
    logic [`HSSP_WORD_W-1:0] tx_q;
    logic [`HSSP_WORD_W-1:0] rx_q;
    logic [`HSSP_WORD_W-1:0] rx_word_q;
    logic                    rx_valid_q;
    logic [1:0]              miso_s_q;
    logic [1:0]              irq_s_q;
    wire half_done = (div_q == 8'h00);
    wire last_bit  = (bits_q == 6'h1F);
    assign o_ready = (st_q == hssp_pkg::HSSP_IDLE);
    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            st_q       <= hssp_pkg::HSSP_IDLE;
            div_q      <= 8'h00;
            bits_q     <= 6'h00;
            sck_q      <= 1'h0;
            cs_n_q     <= 1'h1;
            tx_q       <= 32'h00000000;
            rx_q       <= 32'h00000000;
            rx_word_q  <= 32'h00000000;
            rx_valid_q <= 1'h0;
            miso_s_q   <= 2'h0;
            irq_s_q    <= 2'h0;
        end
        else
        begin
            miso_s_q   <= {miso_s_q[0], link.miso};
            irq_s_q    <= {irq_s_q[0], link.irq};
            rx_valid_q <= 1'h0;
            if (!half_done)
                div_q <= div_q - 8'h01;
            case (st_q)
                hssp_pkg::HSSP_IDLE:
                begin
                    sck_q <= 1'h0;
                    if (i_start)
                    begin
                        tx_q   <= i_tx_word;
                        cs_n_q <= 1'h0;
                        div_q  <= `HSSP_LEAD_HALF;
                        bits_q <= 6'h00;
                        st_q   <= hssp_pkg::HSSP_LEAD;
                    end
                    else if (!i_hold_cs)
                        cs_n_q <= 1'h1;
                end
                hssp_pkg::HSSP_LEAD:
                    if (half_done)
                    begin
                        sck_q <= 1'h1;
                        rx_q  <= {rx_q[`HSSP_WORD_W-2:0], miso_s_q[1]};
                        div_q <= `HSSP_SCK_HALF;
                        st_q  <= hssp_pkg::HSSP_SHIFT;
                    end
                hssp_pkg::HSSP_SHIFT:
                    if (half_done)
                    begin
                        sck_q <= !sck_q;
                        div_q <= `HSSP_SCK_HALF;
                        if (sck_q)
                        begin
                            if (last_bit)
                                st_q <= hssp_pkg::HSSP_DONE;
                            else
                            begin
                                tx_q   <= {tx_q[`HSSP_WORD_W-2:0], 1'h0};
                                bits_q <= bits_q + 6'h01;
                            end
                        end
                        else
                            rx_q <= {rx_q[`HSSP_WORD_W-2:0], miso_s_q[1]};
                    end
                hssp_pkg::HSSP_DONE:
                    if (half_done)
                    begin
                        sck_q      <= 1'h0;
                        rx_word_q  <= rx_q;
                        rx_valid_q <= 1'h1;
                        cs_n_q     <= !i_hold_cs;
                        st_q       <= hssp_pkg::HSSP_IDLE;
                    end
                default:
                    st_q <= hssp_pkg::HSSP_IDLE;
            endcase
        end
    end
    assign link.sck           = sck_q;
    assign link.mosi          = tx_q[`HSSP_WORD_W-1];
    assign link.chip_select_n = cs_n_q;
    assign o_rx_word          = rx_word_q;
    assign o_rx_valid         = rx_valid_q;
    assign o_irq              = irq_s_q[1];
endmodule

// ### src/hssp_if.sv
// Link signals between host master and device slave
`timescale 1ns/1ns
interface hssp_if;
    logic sck;
    logic mosi;
    logic chip_select_n;
    logic miso_o;
    logic miso_oe;
    logic irq;
    wire  miso;
    // Released line reads low, as through a pull-down; the enable marks the release
    assign miso = miso_oe & miso_o;
    modport host
    (
        output sck,
        output mosi,
        output chip_select_n,
        input  miso,
        input  irq
    );
    modport device
    (
        input  sck,
        input  mosi,
        input  chip_select_n,
        output miso_o,
        output miso_oe,
        output irq
    );
endinterface

// ### src/hssp_pkg.sv
// Types shared by both ends of the host serial port
package hssp_pkg;
    // Word size seen on the link
    typedef enum logic [1:0]
    {
        HSSP_SZ_8  = 2'h0,
        HSSP_SZ_16 = 2'h1,
        HSSP_SZ_32 = 2'h2
    } hssp_size_t;
    // Host sequencer, Gray along the usual path
    typedef enum logic [1:0]
    {
        HSSP_IDLE  = 2'h0,
        HSSP_LEAD  = 2'h1,
        HSSP_SHIFT = 2'h3,
        HSSP_DONE  = 2'h2
    } hssp_state_t;
endpackage

// ### verification/host_spi_slave_port_bench.sv
// Bench joining host and device ends over one link
`timescale 1ns/1ns
module host_spi_slave_port_bench;
    typedef struct packed
    {
        logic [31:0] h;
        logic [31:0] d;
        logic        hold;
        logic        swp;
    } hssp_row_t;
    // ==========
    // Rows: host word, device word, hold select, bytes flipped
    hssp_row_t rows [5] = '{
        '{32'hA5C3_0F81, 32'h8000_0001, 1'b0, 1'b0},
        '{32'hFFFF_FFFF, 32'h0000_0000, 1'b0, 1'b0},
        '{32'h0000_0034, 32'h7E5A_C3E1, 1'b0, 1'b1},
        '{32'h1234_5678, 32'hDEAD_BEEF, 1'b1, 1'b0},
        '{32'h00FF_FF00, 32'hDEAD_BEEF, 1'b0, 1'b0}};
    logic                 clk_sys = 1'b0;
    logic                 arst_n  = 1'b0;
    logic [31:0]          h_tx    = 32'h0;
    logic                 h_start = 1'b0;
    logic                 h_hold  = 1'b0;
    logic [31:0]          d_tx    = 32'h0;
    logic                 d_irq   = 1'b0;
    logic                 h_got   = 1'b0;
    logic                 b_got   = 1'b0;
    logic                 h_ready;
    logic                 h_valid;
    logic                 h_irq;
    logic                 d_valid;
    logic                 d_swp;
    logic                 d_swc;
    logic                 b_valid;
    logic [31:0]          h_rx;
    logic [31:0]          h_cap;
    logic [31:0]          d_rx;
    logic [31:0]          d_cap;
    logic [31:0]          b_rx;
    logic [31:0]          b_cap;
    hssp_pkg::hssp_size_t d_sz;
    hssp_pkg::hssp_size_t d_szc;
    hssp_pkg::hssp_size_t b_sz;
    hssp_pkg::hssp_size_t b_szc;
    int                   fails    = 0;
    int                   n_checks = 0;
    always #10 clk_sys = ~clk_sys;
    hssp_if u_hssp_if ();
    hssp_if u_hssp_if_b ();
    hssp_host u_hssp_host (.i_clk_sys(clk_sys), .i_arst_n(arst_n), .link(u_hssp_if.host), .i_tx_word(h_tx),
        .i_start(h_start), .i_hold_cs(h_hold), .o_ready(h_ready), .o_rx_word(h_rx), .o_rx_valid(h_valid),
        .o_irq(h_irq));
    hssp_device u_hssp_device (.i_clk_sys(clk_sys), .i_arst_n(arst_n), .link(u_hssp_if.device), .i_tx_word(d_tx),
        .i_tx_valid(1'b1), .o_tx_taken(), .i_irq_req(d_irq), .o_rx_word(d_rx), .o_rx_valid(d_valid),
        .o_rx_size(d_sz), .o_rx_swapped(d_swp));
    // Second device faces the bench, which breaks framing on purpose
    hssp_device u_hssp_device_b (.i_clk_sys(clk_sys), .i_arst_n(arst_n), .link(u_hssp_if_b.device),
        .i_tx_word(32'h0), .i_tx_valid(1'b1), .o_tx_taken(), .i_irq_req(1'b0), .o_rx_word(b_rx),
        .o_rx_valid(b_valid), .o_rx_size(b_sz), .o_rx_swapped());
    hssp_monitor u_hssp_monitor (.i_clk_sys(clk_sys), .i_arst_n(arst_n), .sck(u_hssp_if.sck),
        .mosi(u_hssp_if.mosi), .chip_select_n(u_hssp_if.chip_select_n), .miso_o(u_hssp_if.miso_o),
        .miso_oe(u_hssp_if.miso_oe), .irq(u_hssp_if.irq));
    // Valid outputs pulse for one cycle, so catch them here
    always @(posedge clk_sys)
    begin
        h_cap <= h_valid ? h_rx : h_cap;
        d_cap <= d_valid ? d_rx : d_cap;
        d_szc <= d_valid ? d_sz : d_szc;
        d_swc <= d_valid ? d_swp : d_swc;
        b_cap <= b_valid ? b_rx : b_cap;
        b_szc <= b_valid ? b_sz : b_szc;
        h_got <= h_got | h_valid;
        b_got <= b_got | b_valid;
    end
    // ==========
    // Tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic test_done;
        $display("checks=%0d mismatches=%0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic xfer(input hssp_row_t r);
        int          k;
        logic [31:0] e;
        e = r.h;
        if (r.swp)
            e = {<<8{r.h}};
        k = 0;
        while (h_ready !== 1'b1 && k < 50)
        begin
            @(negedge clk_sys);
            k++;
        end
        h_tx = r.h;
        h_hold = r.hold;
        d_tx = r.d;
        h_got = 1'b0;
        h_start = 1'b1;
        @(negedge clk_sys);
        h_start = 1'b0;
        k = 0;
        while (h_got !== 1'b1 && k < 600)
        begin
            @(negedge clk_sys);
            k++;
        end
        chk({31'h0, h_got}, 32'h1);
        chk(h_cap, r.d);
        chk(d_cap, e);
        chk({31'h0, d_swc}, {31'h0, r.swp});
        chk({30'h0, d_szc}, {30'h0, hssp_pkg::HSSP_SZ_32});
        chk({31'h0, u_hssp_if_b.miso_oe}, 32'h0);
    endtask
    task automatic irq_to(input logic v);
        int k;
        d_irq = v;
        k = 0;
        while (h_irq !== v && k < 8)
        begin
            @(negedge clk_sys);
            k++;
        end
        chk({31'h0, h_irq}, {31'h0, v});
        chk({31'h0, u_hssp_if.irq}, {31'h0, v});
    endtask
    // Bench-made clock at 160 ns, also run outside frames when sel is low
    task automatic shift_b(input logic [15:0] v, input int n, input logic sel);
        int i;
        b_got = 1'b0;
        u_hssp_if_b.chip_select_n = ~sel;
        for (i = n - 1; i >= 0; i--)
        begin
            u_hssp_if_b.mosi = v[i];
            repeat (4) @(negedge clk_sys);
            u_hssp_if_b.sck = 1'b1;
            repeat (4) @(negedge clk_sys);
            u_hssp_if_b.sck = 1'b0;
        end
        u_hssp_if_b.mosi = ~u_hssp_if_b.mosi;
        repeat (4) @(negedge clk_sys);
        u_hssp_if_b.chip_select_n = 1'b1;
        repeat (12) @(negedge clk_sys);
    endtask
    // ==========
    // Sequence
    initial
    begin
        u_hssp_if_b.sck = 1'b0;
        u_hssp_if_b.mosi = 1'b0;
        u_hssp_if_b.chip_select_n = 1'b1;
        repeat (3) @(negedge clk_sys);
        arst_n = 1'b1;
        chk({28'h0, u_hssp_if.sck, u_hssp_if.chip_select_n, u_hssp_if.miso_oe, u_hssp_if.irq}, 32'h4);
        repeat (2) @(negedge clk_sys);
        $display("test reset done");
        for (int i = 0; i < 5; i++)
            xfer(rows[i]);
        $display("test rows done");
        irq_to(1'b1);
        irq_to(1'b0);
        $display("test irq done");
        shift_b(16'hFFFF, 8, 1'b0);
        chk({31'h0, b_got}, 32'h0);
        shift_b(16'h00C6, 8, 1'b1);
        chk(b_cap & 32'hFF, 32'hC6);
        chk({30'h0, b_szc}, {30'h0, hssp_pkg::HSSP_SZ_8});
        shift_b(16'h9A5B, 16, 1'b1);
        chk(b_cap & 32'hFFFF, 32'h9A5B);
        chk({30'h0, b_szc}, {30'h0, hssp_pkg::HSSP_SZ_16});
        chk({31'h0, u_hssp_if_b.miso_oe}, 32'h0);
        $display("test sizes done");
        test_done;
    end
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        fails++;
        test_done;
    end
endmodule

// ### verification/hssp_monitor.sv
// Checker on the host serial link
`timescale 1ns/1ns
module hssp_monitor
(
    input wire logic i_clk_sys,
    input wire logic i_arst_n,
    input wire logic sck,
    input wire logic mosi,
    input wire logic chip_select_n,
    input wire logic miso_o,
    input wire logic miso_oe,
    input wire logic irq
);
    // ==========
    // Rise count
    logic       sck_q;
    logic [4:0] cnt_q;
    logic [4:0] cnt_d;
    // Wraps at 32, so a held select still ends each word at zero
    assign cnt_d = chip_select_n ? 5'h00 : cnt_q + {4'h0, sck & ~sck_q};
    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            sck_q <= 1'b0;
            cnt_q <= 5'h00;
        end
        else
        begin
            sck_q <= sck;
            cnt_q <= cnt_d;
        end
    end
    // ==========
    // Properties
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_arst_n);
    // Half period and lead are seven system clocks each
    sequence s_lead;
        (!sck) [*7] ##1 sck;
    endsequence
    sequence s_high;
        sck [*7] ##1 !sck;
    endsequence
    sck_idle_a: assert property (chip_select_n |-> !sck)
        else $error("clock active while deselected");
    lead_time_a: assert property ($fell(chip_select_n) |-> s_lead)
        else $error("lead interval wrong");
    sck_high_a: assert property ($rose(sck) |-> s_high)
        else $error("clock high phase wrong");
    mosi_hold_a: assert property (sck && $past(sck) |-> $stable(mosi))
        else $error("data moved while clock high");
    // Word boundary excluded: the next word may load on the last rise
    miso_fall_a: assert property (miso_oe && $past(miso_oe) && $changed(miso_o) && cnt_q != 5'h00 |-> !sck)
        else $error("return data moved while clock high");
    oe_select_a: assert property ($rose(miso_oe) |-> !chip_select_n)
        else $error("return line driven while deselected");
    miso_release_a: assert property (chip_select_n [*6] |-> !miso_oe)
        else $error("return line not released");
    word_count_a: assert property ($rose(chip_select_n) |-> cnt_q == 5'h00)
        else $error("select rose inside a word");
endmodule
